// ==== dv/epwm_bridge_model.sv ====
// far side: comparators, fault pin and pulled-down bridge pins
`timescale 1ns/1ps
module epwm_bridge_model (
    input  logic [2:0] trip,
    input  logic [3:0] out_val,
    input  logic [3:0] out_en,
    output logic       comp1_out,
    output logic       comp2_out,
    output logic       fault_input_pin_n,
    output logic [3:0] pin_level
);
    assign comp1_out = trip[0];
    assign comp2_out = trip[1];
    assign fault_input_pin_n = !trip[2];
    // released pins sag to the pull-down so the switches stay off
    assign pin_level = out_val & out_en;
endmodule

// ==== dv/epwm_core_chk.sv ====
// assertions on the pwm block's bus and timebase ports
`timescale 1ns/1ps
`include "epwm_defines.vh"
module epwm_core_chk (
    input logic        hclk,
    input logic        hresetn,
    input logic        hsel,
    input logic [11:0] haddr,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic [31:0] hwdata,
    input logic        hready,
    input logic [31:0] hrdata,
    input logic        hreadyout,
    input logic        hresp,
    input logic        safe_clock_strap,
    input logic [1:0]  chan1_timebase,
    input logic [1:0]  chan2_timebase,
    input logic [1:0]  chan3_timebase,
    input logic [1:0]  chan4_timebase
);
    logic        dp_wr;
    logic        dp_rd;
    logic        last_wr;
    logic        tb_wr_d;
    logic [11:0] dp_addr;
    logic [7:0]  tb_sh;
    logic [7:0]  sd_sh;
    logic [4:0]  st_sh;
    logic [2:0]  strap_cnt;
    wire         tb_wr = dp_wr && dp_addr == `EPWM_OFS_TIMEBASE;
    wire [7:0]   tb_out = {chan4_timebase, chan3_timebase,
                           chan2_timebase, chan1_timebase};
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // shadows let readback be judged without modelling the shutdown logic
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            last_wr <= 1'b0;
            tb_wr_d <= 1'b0;
            dp_addr <= 12'h000;
            tb_sh <= 8'h00;
            sd_sh <= 8'h00;
            st_sh <= 5'h01;
            strap_cnt <= 3'h0;
        end else begin
            dp_wr <= hready && hsel && htrans[1] && hwrite;
            dp_rd <= hready && hsel && htrans[1] && !hwrite;
            dp_addr <= haddr;
            last_wr <= dp_wr;
            tb_wr_d <= tb_wr;
            if (tb_wr)
                tb_sh <= hwdata[7:0];
            if (dp_wr && dp_addr == `EPWM_OFS_SHUTDOWN)
                sd_sh <= hwdata[7:0];
            if (dp_wr && dp_addr == `EPWM_OFS_STEERING)
                st_sh <= hwdata[4:0];
            if (!safe_clock_strap)
                strap_cnt <= 3'h0;
            else if (strap_cnt != 3'h7)
                strap_cnt <= strap_cnt + 3'h1;
        end
    end
    tb_load_a: assert property (tb_wr |-> ##[1:2] tb_out == tb_sh)
        else $error("timebase outputs missed a write");
    tb_hold_a: assert property (!tb_wr && !tb_wr_d |-> tb_out == tb_sh)
        else $error("timebase outputs drifted");
    tb_read_a: assert property (dp_rd && !last_wr &&
        dp_addr == `EPWM_OFS_TIMEBASE |-> hrdata[7:0] == tb_sh)
        else $error("timebase readback wrong");
    steer_pad_a: assert property (dp_rd &&
        dp_addr == `EPWM_OFS_STEERING |-> hrdata[7:5] == 3'h0)
        else $error("steering top bits not zero");
    steer_back_a: assert property (dp_rd && !last_wr &&
        dp_addr == `EPWM_OFS_STEERING |-> hrdata[4:0] == st_sh)
        else $error("steering readback wrong");
    sd_fields_a: assert property (dp_rd && !last_wr &&
        dp_addr == `EPWM_OFS_SHUTDOWN |-> hrdata[6:0] == sd_sh[6:0])
        else $error("shutdown fields readback wrong");
    strap_zero_a: assert property (dp_rd && strap_cnt == 3'h7 &&
        dp_addr == `EPWM_OFS_RESTART |-> hrdata[7:0] == 8'h00)
        else $error("restart register not forced low");
    bus_ok_a: assert property (hreadyout && !hresp)
        else $error("bus response not ready and okay");
endmodule
bind epwm_core epwm_core_chk epwm_core_chk_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .safe_clock_strap(safe_clock_strap), .chan1_timebase(chan1_timebase),
    .chan2_timebase(chan2_timebase), .chan3_timebase(chan3_timebase),
    .chan4_timebase(chan4_timebase));

// ==== dv/test_enhanced_pwm_shutdown_steering.sv ====
// self-checking bench for the pwm shutdown and steering block
`timescale 1ns/1ps
`include "epwm_defines.vh"
module test_enhanced_pwm_shutdown_steering;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [11:0] haddr = 0;
    logic [1:0]  htrans = 0;
    logic [31:0] hwdata = 0, rd;
    logic        pwm_raw = 0, tick = 0, strap = 0, per = 0;
    logic [3:0]  port_data = 0;
    logic [2:0]  trip = 0;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, a, b, c, d, c1, c2, flt_n;
    wire  [1:0]  tb1, tb2, tb3, tb4;
    wire  [3:0]  oe, pins;
    int          bad_count = 0, comparisons = 0, cycles = 0, n0, n1;
    always #2.5 hclk = ~hclk;
    epwm_core epwm_core_i (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .period_start_first(per),
        .period_start_second(1'b0), .period_start_third(1'b0),
        .pwm_raw(pwm_raw), .lowpower_sync_tick(tick), .comp1_out(c1),
        .comp2_out(c2), .fault_input_pin_n(flt_n), .safe_clock_strap(strap),
        .port_data(port_data), .chan1_timebase(tb1), .chan2_timebase(tb2),
        .chan3_timebase(tb3), .chan4_timebase(tb4), .bridge_out_a(a),
        .bridge_out_b(b), .bridge_out_c(c), .bridge_out_d(d), .bridge_oe(oe));
    epwm_bridge_model epwm_bridge_model_i (.trip(trip), .out_val({d, c, b, a}),
        .out_en(oe), .comp1_out(c1), .comp2_out(c2),
        .fault_input_pin_n(flt_n), .pin_level(pins));
    task give_verdict;
        if (bad_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        comparisons++;
        if (seen !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task bus(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= ad;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task rdc(input logic [11:0] ad, input logic [31:0] e);
        bus(1'b0, ad, 32'h0);
        chk("register", rd, e);
    endtask
    task wt(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task t_regs;
        rdc(12'h000, 32'h00);
        rdc(12'h004, 32'h00);
        rdc(12'h008, 32'h00);
        rdc(12'h00C, 32'h01);
        bus(1'b1, 12'h020, 32'hFF);
        rdc(12'h020, 32'h00);
        bus(1'b1, 12'h000, 32'hE4);
        rdc(12'h000, 32'hE4);
        wt(3);
        chk("timebase", {tb4, tb3, tb2, tb1}, 8'hE4);
        bus(1'b1, 12'h000, 32'h1B);
        wt(3);
        chk("timebase", {tb4, tb3, tb2, tb1}, 8'h1B);
        bus(1'b1, 12'h00C, 32'hFF);
        rdc(12'h00C, 32'h1F);
    endtask
    task t_steer;
        bus(1'b1, 12'h010, 32'h00);
        port_data <= 4'hA;
        wt(8);
        chk("port pins", {d, c, b, a}, 4'hA);
        bus(1'b1, 12'h010, 32'h0E);
        bus(1'b1, 12'h00C, 32'h0F);
        wt(8);
        chk("polarity", {d, c, b, a}, 4'h5);
        bus(1'b1, 12'h00C, 32'h00);
        wt(8);
        chk("unsteered", {d, c, b, a}, 4'hA);
        bus(1'b1, 12'h010, 32'h0C);
        bus(1'b1, 12'h00C, 32'h0F);
    endtask
    task t_steer_sync;
        bus(1'b1, 12'h000, 32'h00);
        bus(1'b1, 12'h00C, 32'h11);
        wt(8);
        rdc(12'h018, 32'h1F);
        per <= 1'b1;
        @(posedge hclk);
        per <= 1'b0;
        wt(4);
        rdc(12'h018, 32'h01);
        bus(1'b1, 12'h00C, 32'h0F);
    endtask
    task t_sources;
        logic e;
        for (int code = 0; code < 8; code++) begin
            for (int k = 0; k < 3; k++) begin
                e = (code >> k) & 1;
                bus(1'b1, 12'h008, 32'h80);
                bus(1'b1, 12'h004, {code[2:0], 4'h4});
                trip <= 3'h1 << k;
                wt(10);
                bus(1'b0, 12'h004, 32'h0);
                chk("shutdown", rd[7], e);
                if (e)
                    chk("safe pins", {d, c, b, a}, 4'h5);
                trip <= 3'h0;
                wt(10);
                bus(1'b0, 12'h004, 32'h0);
                chk("restart", rd[7], 1'b0);
            end
        end
    endtask
    task t_sync;
        bus(1'b1, 12'h014, 32'h10);
        bus(1'b1, 12'h004, 32'h14);
        trip <= 3'h1;
        wt(10);
        bus(1'b0, 12'h004, 32'h0);
        chk("sync wait", rd[7], 1'b0);
        tick <= 1'b1;
        wt(2);
        tick <= 1'b0;
        wt(10);
        bus(1'b0, 12'h004, 32'h0);
        chk("sync trip", rd[7], 1'b1);
        trip <= 3'h0;
        tick <= 1'b1;
        wt(2);
        tick <= 1'b0;
        wt(10);
        bus(1'b1, 12'h014, 32'h00);
    endtask
    task t_manual;
        bus(1'b1, 12'h008, 32'h00);
        bus(1'b1, 12'h004, 32'h4A);
        trip <= 3'h4;
        wt(10);
        chk("tristate", {oe, pins}, 8'h00);
        bus(1'b1, 12'h004, 32'h4A);
        wt(4);
        rdc(12'h004, 32'hCA);
        trip <= 3'h0;
        wt(10);
        rdc(12'h004, 32'hCA);
        bus(1'b1, 12'h004, 32'h4A);
        wt(4);
        rdc(12'h004, 32'h4A);
    endtask
    task measure(input logic [31:0] dc, output int n);
        bus(1'b1, 12'h008, dc);
        bus(1'b1, 12'h004, 32'h00);
        wt(20);
        pwm_raw <= 1'b1;
        n = 0;
        @(posedge hclk);
        while (a !== 1'b1 && n < 700) begin
            @(posedge hclk);
            n++;
        end
        pwm_raw <= 1'b0;
    endtask
    initial begin
        wt(4);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_steer();
        t_steer_sync();
        t_sources();
        t_sync();
        t_manual();
        strap <= 1'b1;
        wt(5);
        bus(1'b1, 12'h008, 32'hFF);
        rdc(12'h008, 32'h00);
        strap <= 1'b0;
        wt(5);
        bus(1'b1, 12'h008, 32'h85);
        rdc(12'h008, 32'h85);
        measure(32'h00, n0);
        measure(32'h05, n1);
        // instruction-cycle phase puts the gap anywhere from 18 to 21 cycles
        chk("delay", n1 - n0 >= 17 && n1 - n0 <= 23, 1'b1);
        give_verdict();
    end
endmodule

// ==== logic/epwm_core.v ====
// enhanced pwm steering, auto-shutdown, dead-band and timebase selection
// Operation
// (RQ1) per-channel select: 00 first, 01 second, 10 third timer, 11 reserved.
// (RQ2) timebase register: ch4 bits 7-6, ch3 5-4, ch2 3-2, ch1 1-0.
// (RQ3) shutdown status bit 7 reads 1 while outputs held in safe state.
// (RQ4) source code 000 ignores all shutdown sources.
// (RQ5) codes 001/010/011: comparator one, two, or either high.
// (RQ6) 100 fault pin low; 101-111 add comparator one, two or both.
// (RQ7) shutdown drives A and C low 00, high 01, tri-state 1x.
// (RQ8) shutdown drives B and D low 00, high 01, tri-state 1x.
// (RQ9) with sync option, comparator shutdown waits for low-power timer tick.
// (RQ10) restart enable: status clears itself once condition goes away.
// (RQ11) restart disabled: status held until software clears it.
// (RQ12) seven-bit delay counts instruction cycles before active edge.
// (RQ13) clock-safety straps force the restart/delay register bits to 0.
// (RQ14) steering sync 1 updates at next period, 0 at instruction boundary.
// (RQ15) steering bits 0-3 route polarised pwm to A-D, else port pin.
// (RQ16) steering applies only in pwm mode with single output configuration.
// (RQ17) steering bits 7-5 read zero and ignore writes.
// (RQ18) low mode bits set polarity for A/C and B/D pairs.
// (RQ19) single output modulates A only; others are port pins unless steered.
// (RQ20) while shut down, safe states override waveform and steering; code applies them only to steered pins in pwm mode, port pins stay ports.
`timescale 1ns/1ps
`include "epwm_defines.vh"
module epwm_core (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        clk_en,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        period_start_first,
    input  wire        period_start_second,
    input  wire        period_start_third,
    input  wire        pwm_raw,
    input  wire        lowpower_sync_tick,
    input  wire        comp1_out,
    input  wire        comp2_out,
    input  wire        fault_input_pin_n,
    input  wire        safe_clock_strap,
    input  wire [3:0]  port_data,
    output reg  [1:0]  chan1_timebase,
    output reg  [1:0]  chan2_timebase,
    output reg  [1:0]  chan3_timebase,
    output reg  [1:0]  chan4_timebase,
    output reg         bridge_out_a,
    output reg         bridge_out_b,
    output reg         bridge_out_c,
    output reg         bridge_out_d,
    output reg  [3:0]  bridge_oe
);

    localparam ST_RUN  = 2'b01;
    localparam ST_SHUT = 2'b10;

    reg  [7:0] pwm_timebase_select;
    reg  [7:0] auto_shutdown_cfg;
    reg  [7:0] restart_and_delay_control;
    reg  [4:0] output_steering_control;
    reg  [7:0] chan_ctrl;
    reg  [3:0] port_oe;
    reg  [1:0] sd_state;
    reg  [3:0] steer_live;
    reg        steer_pending;
    reg  [1:0] instr_phase;
    reg  [6:0] dly_cnt;
    reg        pwm_dly;
    reg        pwm_prev;
    reg  [1:0] pa_sync;
    reg  [1:0] pb_sync;
    reg  [1:0] pc_sync;
    reg  [1:0] c1_sync;
    reg  [1:0] c2_sync;
    reg  [1:0] flt_sync;
    reg  [1:0] tick_sync;
    reg  [1:0] pwm_sync;
    reg  [1:0] strap_sync;
    reg        c1_held;
    reg        c2_held;
    reg        comparator_sync_enable;
    reg        wr_pend;
    reg  [11:0] wr_addr;
    reg        sw_clear;
    reg  [31:0] next_rdata;

    wire [2:0] shutdown_source_sel = auto_shutdown_cfg[6:4];
    wire [1:0] pair_ac_safe_state  = auto_shutdown_cfg[3:2];
    wire [1:0] pair_bd_safe_state  = auto_shutdown_cfg[1:0];
    wire       auto_restart_enable = restart_and_delay_control[7];
    wire [6:0] deadband_delay_count = restart_and_delay_control[6:0];
    wire       steering_update_sync = output_steering_control[4];
    wire [3:0] channel_mode_sel     = chan_ctrl[3:0];
    wire [1:0] output_config_sel    = chan_ctrl[7:6];
    wire       instr_edge = (instr_phase == `EPWM_CYC_PER_INSTR);
    wire       rd_ok  = hsel & hready & htrans[1] & ~hwrite;
    wire       wr_ok  = hsel & hready & htrans[1] & hwrite;

    // period start of the timer chosen for channel one
    function sel_period;
        input [1:0] sel;
        input       p0;
        input       p1;
        input       p2;
        begin
            case (sel)
                `EPWM_TB_FIRST:  sel_period = p0; // RQ1
                `EPWM_TB_SECOND: sel_period = p1; // RQ1
                `EPWM_TB_THIRD:  sel_period = p2; // RQ1
                default:         sel_period = 1'b0;
            endcase
        end
    endfunction

    // safe-state pin value and enable from a two-bit field
    function [1:0] safe_pin;
        input [1:0] field;
        begin
            if (field[1])
                safe_pin = 2'b00;
            else if (field == `EPWM_SAFE_HIGH)
                safe_pin = 2'b11;
            else
                safe_pin = 2'b01;
        end
    endfunction

    // pick only after each timer pin is synchronised on its own
    wire period_now = sel_period(pwm_timebase_select[1:0], pa_sync[1],
                                 pb_sync[1], pc_sync[1]);

    // two-flop synchronisers for every pin input
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_sync    <= 2'b00;
            pb_sync    <= 2'b00;
            pc_sync    <= 2'b00;
            c1_sync    <= 2'b00;
            c2_sync    <= 2'b00;
            flt_sync   <= 2'b11;
            tick_sync  <= 2'b00;
            pwm_sync   <= 2'b00;
            strap_sync <= 2'b00;
        end else if (clk_en) begin
            pa_sync    <= {pa_sync[0], period_start_first};
            pb_sync    <= {pb_sync[0], period_start_second};
            pc_sync    <= {pc_sync[0], period_start_third};
            c1_sync    <= {c1_sync[0], comp1_out};
            c2_sync    <= {c2_sync[0], comp2_out};
            flt_sync   <= {flt_sync[0], fault_input_pin_n};
            tick_sync  <= {tick_sync[0], lowpower_sync_tick};
            pwm_sync   <= {pwm_sync[0], pwm_raw};
            strap_sync <= {strap_sync[0], safe_clock_strap};
        end
    end

    // comparator outputs resampled on the low-power timer tick when enabled
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            c1_held <= 1'b0;
            c2_held <= 1'b0;
        end else if (clk_en && tick_sync[1]) begin
            c1_held <= c1_sync[1]; // RQ9
            c2_held <= c2_sync[1]; // RQ9
        end
    end

    wire c1_eff = comparator_sync_enable ? c1_held : c1_sync[1]; // RQ9
    wire c2_eff = comparator_sync_enable ? c2_held : c2_sync[1]; // RQ9
    wire flt_low = ~flt_sync[1];

    reg  sd_cond;
    always @* begin
        case (shutdown_source_sel)
            3'h0: sd_cond = 1'b0;                              // RQ4
            3'h1: sd_cond = c1_eff;                            // RQ5
            3'h2: sd_cond = c2_eff;                            // RQ5
            3'h3: sd_cond = c1_eff | c2_eff;                   // RQ5
            3'h4: sd_cond = flt_low;                           // RQ6
            3'h5: sd_cond = flt_low | c1_eff;                  // RQ6
            3'h6: sd_cond = flt_low | c2_eff;                  // RQ6
            default: sd_cond = flt_low | c1_eff | c2_eff;      // RQ6
        endcase
    end

    // ahb-lite slave: reads answered in the data phase, writes land one
    // cycle after the address phase, zero wait states
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
        end else if (clk_en) begin
            wr_pend   <= wr_ok;
            if (wr_ok)
                wr_addr <= haddr;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_ok)
                hrdata <= next_rdata;
        end
    end

    always @* begin
        next_rdata = 32'h00000000;
        case (haddr)
            `EPWM_OFS_TIMEBASE:
                next_rdata = {24'h000000, pwm_timebase_select};
            `EPWM_OFS_SHUTDOWN:
                next_rdata = {24'h000000, sd_state == ST_SHUT,
                              auto_shutdown_cfg[6:0]};          // RQ3
            `EPWM_OFS_RESTART:
                next_rdata = {24'h000000, restart_and_delay_control};
            `EPWM_OFS_STEERING:
                next_rdata = {27'h0000000, output_steering_control}; // RQ17
            `EPWM_OFS_CHAN_CTRL:
                next_rdata = {24'h000000, chan_ctrl};
            `EPWM_OFS_PORT_CTRL:
                next_rdata = {27'h0000000, comparator_sync_enable, port_oe};
            `EPWM_OFS_STATUS:
                next_rdata = {27'h0000000, steer_pending, steer_live};
            default:
                next_rdata = 32'h00000000;
        endcase
    end

    // register writes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_timebase_select       <= `EPWM_RST_TIMEBASE;
            auto_shutdown_cfg         <= `EPWM_RST_SHUTDOWN;
            restart_and_delay_control <= `EPWM_RST_RESTART;
            output_steering_control   <= `EPWM_RST_STEERING;
            chan_ctrl                 <= `EPWM_RST_CHAN_CTRL;
            port_oe                   <= 4'h0;
            comparator_sync_enable    <= 1'b0;
            sw_clear                  <= 1'b0;
        end else if (clk_en) begin
            sw_clear <= 1'b0;
            if (strap_sync[1])
                restart_and_delay_control <= 8'h00; // RQ13
            if (wr_pend) begin
                case (wr_addr)
                    `EPWM_OFS_TIMEBASE:
                        pwm_timebase_select <= hwdata[7:0]; // RQ2
                    `EPWM_OFS_SHUTDOWN: begin
                        auto_shutdown_cfg <= {1'b0, hwdata[6:0]};
                        sw_clear <= ~hwdata[`EPWM_SD_STATUS_BIT]; // RQ11
                    end
                    `EPWM_OFS_RESTART:
                        if (!strap_sync[1])
                            restart_and_delay_control <= hwdata[7:0];
                    `EPWM_OFS_STEERING:
                        output_steering_control <= hwdata[4:0]; // RQ17
                    `EPWM_OFS_CHAN_CTRL:
                        chan_ctrl <= hwdata[7:0];
                    `EPWM_OFS_PORT_CTRL: begin
                        port_oe                <= hwdata[3:0];
                        comparator_sync_enable <= hwdata[4];
                    end
                    default: ;
                endcase
            end
        end
    end

    // shutdown state machine; a live condition beats a software clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sd_state <= ST_RUN;
        end else if (clk_en) begin
            case (sd_state)
                ST_RUN:
                    if (sd_cond)
                        sd_state <= ST_SHUT; // RQ3
                ST_SHUT:
                    if (!sd_cond && auto_restart_enable)
                        sd_state <= ST_RUN;  // RQ10
                    else if (!sd_cond && sw_clear)
                        sd_state <= ST_RUN;  // RQ11
                default:
                    sd_state <= ST_RUN;
            endcase
        end
    end

    // instruction-cycle phase and dead-band delay on the active edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_phase <= 2'h0;
            dly_cnt     <= 7'h00;
            pwm_dly     <= 1'b0;
            pwm_prev    <= 1'b0;
        end else if (clk_en) begin
            instr_phase <= instr_phase + 2'h1;
            pwm_prev    <= pwm_sync[1];
            if (!pwm_sync[1]) begin
                pwm_dly <= 1'b0;
                dly_cnt <= 7'h00;
            end else if (!pwm_prev) begin
                dly_cnt <= deadband_delay_count; // RQ12
                pwm_dly <= (deadband_delay_count == 7'h00);
            end else if (dly_cnt == 7'h00) begin
                pwm_dly <= 1'b1;
            end else if (instr_edge) begin
                dly_cnt <= dly_cnt - 7'h01; // RQ12
            end
        end
    end

    // steering update timing
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            steer_live    <= `EPWM_RST_STEER_EN;
            steer_pending <= 1'b0;
        end else if (clk_en) begin
            if (steering_update_sync) begin
                if (steer_live != output_steering_control[3:0])
                    steer_pending <= 1'b1;
                if (period_now) begin
                    steer_live    <= output_steering_control[3:0]; // RQ14
                    steer_pending <= 1'b0;
                end
            end else if (instr_edge) begin
                steer_live    <= output_steering_control[3:0]; // RQ14
                steer_pending <= 1'b0;
            end
        end
    end

    wire steer_mode = (channel_mode_sel[3:2] == `EPWM_CC_MODE_PWM) &&
                      (output_config_sel == `EPWM_CC_CFG_SINGLE); // RQ16
    wire pol_ac = pwm_dly ^ channel_mode_sel[1]; // RQ18
    wire pol_bd = pwm_dly ^ channel_mode_sel[0]; // RQ18
    wire [3:0] wave = {pol_bd, pol_ac, pol_bd, pol_ac};
    wire [3:0] route = steer_mode ? steer_live : 4'h1; // RQ15 RQ19
    wire pwm_on = (channel_mode_sel[3:2] == `EPWM_CC_MODE_PWM);
    wire [1:0] safe_ac = safe_pin(pair_ac_safe_state); // RQ7
    wire [1:0] safe_bd = safe_pin(pair_bd_safe_state); // RQ8

    // output pins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bridge_out_a   <= 1'b0;
            bridge_out_b   <= 1'b0;
            bridge_out_c   <= 1'b0;
            bridge_out_d   <= 1'b0;
            bridge_oe      <= 4'h0;
            chan1_timebase <= 2'h0;
            chan2_timebase <= 2'h0;
            chan3_timebase <= 2'h0;
            chan4_timebase <= 2'h0;
        end else if (clk_en) begin
            chan1_timebase <= pwm_timebase_select[1:0]; // RQ2
            chan2_timebase <= pwm_timebase_select[3:2]; // RQ2
            chan3_timebase <= pwm_timebase_select[5:4]; // RQ2
            chan4_timebase <= pwm_timebase_select[7:6]; // RQ2
            if (sd_state == ST_SHUT && pwm_on) begin // RQ20
                // safe state wins on steered pins; port pins stay ports
                bridge_out_a <= route[0] ? safe_ac[1] : port_data[0]; // RQ7
                bridge_out_c <= route[2] ? safe_ac[1] : port_data[2]; // RQ7
                bridge_out_b <= route[1] ? safe_bd[1] : port_data[1]; // RQ8
                bridge_out_d <= route[3] ? safe_bd[1] : port_data[3]; // RQ8
                bridge_oe    <= {route[3] ? safe_bd[0] : port_oe[3],
                                 route[2] ? safe_ac[0] : port_oe[2],
                                 route[1] ? safe_bd[0] : port_oe[1],
                                 route[0] ? safe_ac[0] : port_oe[0]};
            end else if (pwm_on) begin
                bridge_out_a <= route[0] ? wave[0] : port_data[0]; // RQ15
                bridge_out_b <= route[1] ? wave[1] : port_data[1]; // RQ15
                bridge_out_c <= route[2] ? wave[2] : port_data[2]; // RQ15
                bridge_out_d <= route[3] ? wave[3] : port_data[3]; // RQ15
                bridge_oe    <= route | port_oe;
            end else begin
                bridge_out_a <= port_data[0];
                bridge_out_b <= port_data[1];
                bridge_out_c <= port_data[2];
                bridge_out_d <= port_data[3];
                bridge_oe    <= port_oe;
            end
        end
    end

endmodule

// ==== logic/epwm_defines.vh ====
// register map, field positions, reset values and codes for the pwm block
`ifndef EPWM_DEFINES_VH
`define EPWM_DEFINES_VH

`define EPWM_OFS_TIMEBASE     12'h000
`define EPWM_OFS_SHUTDOWN     12'h004
`define EPWM_OFS_RESTART      12'h008
`define EPWM_OFS_STEERING     12'h00C
`define EPWM_OFS_CHAN_CTRL    12'h010
`define EPWM_OFS_PORT_CTRL    12'h014
`define EPWM_OFS_STATUS       12'h018

`define EPWM_RST_TIMEBASE     8'h00
`define EPWM_RST_SHUTDOWN     8'h00
`define EPWM_RST_RESTART      8'h00
`define EPWM_RST_STEERING     5'h01
`define EPWM_RST_STEER_EN     4'h1
`define EPWM_RST_CHAN_CTRL    8'h00
`define EPWM_RST_PORT_CTRL    8'h00

`define EPWM_SD_STATUS_BIT    7
`define EPWM_SD_SRC_HI        6
`define EPWM_SD_SRC_LO        4
`define EPWM_SD_AC_HI         3
`define EPWM_SD_AC_LO         2
`define EPWM_SD_BD_HI         1
`define EPWM_SD_BD_LO         0
`define EPWM_RS_EN_BIT        7
`define EPWM_ST_SYNC_BIT      4
`define EPWM_ST_MASK          8'h1F
`define EPWM_CC_MODE_PWM      2'h3
`define EPWM_CC_CFG_SINGLE    2'h0

`define EPWM_TB_FIRST         2'h0
`define EPWM_TB_SECOND        2'h1
`define EPWM_TB_THIRD         2'h2

`define EPWM_SAFE_LOW         2'h0
`define EPWM_SAFE_HIGH        2'h1

`define EPWM_CYC_PER_INSTR    2'h3

`endif
